// File: inc/omlsc_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface omlsc_link_if;
  logic h_scl_o;
  logic h_scl_oe;
  logic h_sda_o;
  logic h_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic d_int_o;
  logic d_int_oe;
  logic d_prs_o;
  logic d_prs_oe;
  logic module_select_n;
  logic module_reset_n;
  logic low_power_request;
  logic scl;
  logic sda;
  logic attention_n;
  logic module_present_n;
  // open-drain wires with board pull-ups
  assign scl = h_scl_oe ? h_scl_o : 1'b1;
  assign sda = (h_sda_oe ? h_sda_o : 1'b1) & (d_sda_oe ? d_sda_o : 1'b1);
  assign attention_n = d_int_oe ? d_int_o : 1'b1;
  assign module_present_n = d_prs_oe ? d_prs_o : 1'b1;
  modport device (
    input  scl, sda, module_select_n, module_reset_n, low_power_request,
    output d_sda_o, d_sda_oe, d_int_o, d_int_oe, d_prs_o, d_prs_oe
  );
  modport host (
    input  sda, attention_n, module_present_n,
    output h_scl_o, h_scl_oe, h_sda_o, h_sda_oe,
    output module_select_n, module_reset_n, low_power_request
  );
endinterface
`default_nettype wire

// File: inc/omlsc_pkg.sv
// Function
// - serial bus answered only while selected
// - host selects only the addressed module
// - long reset pulse restores all defaults
// - host ignores status until completion interrupt
// - completion raises interrupt, clears not-ready
// - power-up posts completion interrupt unprompted
// - low-power input limits module power
// - module grounds presence line when inserted
// - host pulls presence line up
// - interrupt low reports fault or status
// - host reads cause over serial bus
// - interrupt is open collector
// - fully functional within 2000 ms
// - lanes addressable, each shut down alone
package omlsc_pkg;
  localparam int unsigned CLK_KHZ          = 100000;
  localparam int unsigned INIT_TIME_MS     = 2000;
  localparam int unsigned INIT_CYCLES      = INIT_TIME_MS * CLK_KHZ;
  localparam int unsigned RESET_MIN_CYCLES = 1000;
  localparam int unsigned SCL_QUARTER      = 10;
  localparam logic [6:0]  DEV_ADDR         = 7'h50;
  // module memory map
  localparam logic [7:0]  REG_STATUS       = 8'h00;
  localparam logic [7:0]  REG_FLAGS        = 8'h01;
  localparam logic [7:0]  REG_MASK         = 8'h02;
  localparam logic [7:0]  REG_LANE_OFF     = 8'h03;
  localparam int unsigned FLG_DONE         = 0;
  localparam logic [4:0]  MASK_RST         = 5'h00;
  localparam logic [3:0]  LANE_OFF_RST     = 4'h0;
  // host controller registers
  localparam logic [7:0]  HREG_CTRL        = 8'h00;
  localparam logic [7:0]  HREG_CMD         = 8'h04;
  localparam logic [7:0]  HREG_STAT        = 8'h08;
  localparam logic [7:0]  HREG_IRQ         = 8'h0c;
  localparam logic [7:0]  HREG_MASK        = 8'h10;
  localparam logic [1:0]  CTRL_RST         = 2'h0;
  localparam logic [2:0]  HMASK_RST        = 3'h0;
  typedef enum {SL_IDLE, SL_RECV, SL_ACK, SL_SEND, SL_RACK} omlsc_slv_type;
  typedef enum {MS_IDLE, MS_START, MS_BIT, MS_STOP} omlsc_mst_type;
endpackage

// File: test/omlsc_props.sv
`timescale 1ns/10ps
`default_nettype none
module omlsc_props #(
  parameter int unsigned INIT_CYC = 200,
  parameter int unsigned RST_MIN  = 8
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // link
  input wire logic module_select_n,
  input wire logic module_reset_n,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  input wire logic d_int_o,
  input wire logic d_int_oe,
  input wire logic d_prs_o,
  input wire logic d_prs_oe
);
  logic [15:0] low_q;
  logic [15:0] cnt_q;
  logic        arm_q;
  // length of the current module reset pulse
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_q <= '0;
    end else if (module_reset_n) begin
      low_q <= '0;
    end else if (low_q != 16'hffff) begin
      low_q <= low_q + 16'h1;
    end
  end
  // cycles spent initialising since reset release
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      arm_q <= 1'b1;
      cnt_q <= '0;
    end else if (!module_reset_n && low_q > 16'(RST_MIN + 4)) begin
      arm_q <= 1'b1;
      cnt_q <= '0;
    end else if (arm_q) begin
      arm_q <= !d_int_oe;
      cnt_q <= cnt_q + 16'h1;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sel_gate_a: assert property (module_select_n [*5] |-> !d_sda_oe)
    else $error("device drives data while deselected");
  od_int_a: assert property (d_int_oe |-> !d_int_o)
    else $error("attention driven high");
  od_sda_a: assert property (d_sda_oe |-> !d_sda_o)
    else $error("data line driven high");
  prs_gnd_a: assert property (d_prs_oe |-> !d_prs_o)
    else $error("presence line not grounded");
  rst_clear_a: assert property (low_q > 16'(RST_MIN + 8) |-> !d_int_oe)
    else $error("attention held through long reset");
  no_early_a: assert property (arm_q && cnt_q + 16'h2 < 16'(INIT_CYC) |-> !d_int_oe)
    else $error("completion posted too early");
  init_bound_a: assert property (arm_q |-> cnt_q <= 16'(INIT_CYC + 12))
    else $error("completion not posted in time");
  short_rst_a: assert property (!module_reset_n && low_q < 16'(RST_MIN) && d_int_oe
    && module_select_n |=> d_int_oe)
    else $error("short reset pulse acted");
endmodule
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import omlsc_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        rst_i;
  logic        clk_en_i;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [31:0] rdata_o;
  logic        irq_o;
  logic        inserted_i;
  logic [3:0]  fault_i;
  logic [3:0]  lane_enable_o;
  logic        power_limit_o;
  logic        ready_o;
  int          n_fail;
  int          num_checks;
  int          cyc;
  omlsc_link_if link ();
  omlsc_device #(.INIT_CYC(200), .RST_MIN(8)) u_omlsc_device (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .link(link),
    .inserted_i(inserted_i), .fault_i(fault_i), .lane_enable_o(lane_enable_o),
    .power_limit_o(power_limit_o), .ready_o(ready_o));
  omlsc_host u_omlsc_host (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .link(link),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .irq_o(irq_o));
  omlsc_props #(.INIT_CYC(200), .RST_MIN(8)) u_omlsc_props (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .module_select_n(link.module_select_n),
    .module_reset_n(link.module_reset_n), .d_sda_o(link.d_sda_o), .d_sda_oe(link.d_sda_oe),
    .d_int_o(link.d_int_o), .d_int_oe(link.d_int_oe), .d_prs_o(link.d_prs_o),
    .d_prs_oe(link.d_prs_oe));
  always #5 sys_clk_i = ~sys_clk_i;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      tally_and_finish;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // serial transfer through the host, returns the byte read
  task automatic xfer(input logic [7:0] p, input logic [7:0] d, input logic r,
                      output logic [7:0] q);
    logic [31:0] s;
    int          i;
    wr(HREG_CMD, {15'h0, r, d, p});
    i = 0;
    do begin
      rd(HREG_STAT, s);
      i++;
    end while (s[0] !== 1'b0 && i < 3000);
    chk1(s[0], 1'b0);
    q = s[15:8];
  endtask
  task automatic dchk(input logic [7:0] p, input logic [7:0] exp);
    logic [7:0] q;
    xfer(p, 8'h00, 1'b1, q);
    chk({24'h0, q}, {24'h0, exp});
  endtask
  task automatic wait_irq;
    for (int i = 0; i < 400 && irq_o !== 1'b1; i++) @(posedge sys_clk_i);
    chk1(irq_o, 1'b1);
  endtask
  initial begin
    logic [31:0] s;
    logic [7:0]  q;
    clk_en_i   = 1'b1;
    rst_i      = 1'b1;
    addr_i     = 8'h00;
    wdata_i    = 32'h0;
    wr_i       = 1'b0;
    rd_i       = 1'b0;
    inserted_i = 1'b1;
    fault_i    = 4'h0;
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    rd(HREG_STAT, s);
    chk(s & 32'h1c, 32'h14);
    chk1(ready_o, 1'b0);
    wr(HREG_MASK, 32'h2);
    wait_irq;
    chk1(link.attention_n, 1'b0);
    rd(HREG_IRQ, s);
    chk(s & 32'h2, 32'h2);
    chk({27'h0, ready_o, lane_enable_o}, 32'h1f);
    dchk(REG_STATUS, 8'h04);
    dchk(REG_FLAGS, 8'h01);
    xfer(REG_FLAGS, 8'h01, 1'b0, q);
    chk1(link.attention_n, 1'b1);
    wr(HREG_IRQ, 32'h7);
    xfer(REG_LANE_OFF, 8'h05, 1'b0, q);
    chk({28'h0, lane_enable_o}, 32'ha);
    dchk(REG_LANE_OFF, 8'h05);
    @(posedge sys_clk_i);
    clk_en_i <= 1'b0;
    fault_i  <= 4'h1;
    @(posedge sys_clk_i);
    fault_i <= 4'h0;
    repeat (3) @(posedge sys_clk_i);
    clk_en_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    chk1(link.attention_n, 1'b1);
    wr(HREG_CTRL, 32'h2);
    repeat (8) @(posedge sys_clk_i);
    chk1(power_limit_o, 1'b1);
    dchk(REG_STATUS, 8'h06);
    @(posedge sys_clk_i);
    fault_i <= 4'h4;
    @(posedge sys_clk_i);
    fault_i <= 4'h0;
    repeat (6) @(posedge sys_clk_i);
    chk1(link.attention_n, 1'b0);
    dchk(REG_FLAGS, 8'h08);
    xfer(REG_MASK, 8'h01, 1'b0, q);
    dchk(REG_MASK, 8'h01);
    chk1(link.attention_n, 1'b0);
    wr(HREG_CTRL, 32'h3);
    wr(HREG_CTRL, 32'h2);
    repeat (20) @(posedge sys_clk_i);
    chk1(link.attention_n, 1'b0);
    chk({28'h0, lane_enable_o}, 32'ha);
    rd(HREG_STAT, s);
    chk(s & 32'h10, 32'h10);
    wr(HREG_CTRL, 32'h1);
    repeat (30) @(posedge sys_clk_i);
    chk({27'h0, ready_o, lane_enable_o}, 32'h0);
    chk1(link.attention_n, 1'b1);
    wr(HREG_IRQ, 32'h7);
    wr(HREG_CTRL, 32'h0);
    wait_irq;
    chk({27'h0, ready_o, lane_enable_o}, 32'h1f);
    dchk(REG_LANE_OFF, 8'h00);
    dchk(REG_MASK, 8'h00);
    dchk(REG_STATUS, 8'h04);
    @(posedge sys_clk_i);
    inserted_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    chk1(link.module_present_n, 1'b1);
    rd(HREG_STAT, s);
    chk(s & 32'h4, 32'h0);
    tally_and_finish;
  end
endmodule
`default_nettype wire

// File: verilog/omlsc_device.sv
`timescale 1ns/10ps
`default_nettype none
module omlsc_device
  import omlsc_pkg::*;
#(
  parameter int unsigned INIT_CYC = INIT_CYCLES,
  parameter int unsigned RST_MIN  = RESET_MIN_CYCLES
) (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       clk_en_i,
  // link
  omlsc_link_if.device    link,
  // module side
  input  wire logic       inserted_i,
  input  wire logic [3:0] fault_i,
  output var  logic [3:0] lane_enable_o,
  output var  logic       power_limit_o,
  output var  logic       ready_o
);
  logic [4:0]    pin_s;
  logic          s_scl;
  logic          s_sda;
  logic          s_sel_n;
  logic          s_rst_n;
  logic          s_lp;
  logic          scl_p_q;
  logic          sda_p_q;
  logic          scl_rise;
  logic          scl_fall;
  logic          start;
  logic          stop;
  logic [31:0]   rlow_q;
  logic          soft_rst;
  logic          nrdy_q;
  logic [31:0]   init_q;
  logic          done_ev;
  logic [4:0]    flags_q;
  logic [4:0]    mask_q;
  logic [3:0]    lane_off_q;
  logic [4:0]    flg_set;
  logic [4:0]    flg_clr;
  omlsc_slv_type st_q;
  logic [7:0]    sh_q;
  logic [7:0]    ptr_q;
  logic [2:0]    bit_q;
  logic [1:0]    phase_q;
  logic          rw_q;
  logic          nack_q;
  logic          wr_q;
  logic [7:0]    wadr_q;
  logic [7:0]    wdat_q;
  logic [7:0]    rx_byte;

  omlsc_sync #(
    .W   (5),
    .RST (5'h1e)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .clk_en_i  (clk_en_i),
    .d_i       ({link.scl, link.sda, link.module_select_n,
                 link.module_reset_n, link.low_power_request}),
    .q_o       (pin_s)
  );
  assign {s_scl, s_sda, s_sel_n, s_rst_n, s_lp} = pin_s;

  // bus edges and conditions
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (clk_en_i) begin
      scl_p_q <= s_scl;
      sda_p_q <= s_sda;
    end
  end
  assign scl_rise = s_scl & ~scl_p_q;
  assign scl_fall = ~s_scl & scl_p_q;
  assign start    = s_scl & scl_p_q & sda_p_q & ~s_sda;
  assign stop     = s_scl & scl_p_q & ~sda_p_q & s_sda;
  assign rx_byte  = {sh_q[6:0], s_sda};

  // reset pulse filter
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rlow_q <= 32'h0;
    end else if (clk_en_i) begin
      if (s_rst_n) begin
        rlow_q <= 32'h0;
      end else if (rlow_q < RST_MIN) begin
        rlow_q <= rlow_q + 32'h1;
      end
    end
  end
  assign soft_rst = ~s_rst_n & (rlow_q >= RST_MIN);

  // initialisation timer and not-ready
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      nrdy_q <= 1'b1;
      init_q <= 32'h0;
    end else if (clk_en_i) begin
      if (soft_rst) begin
        nrdy_q <= 1'b1;
        init_q <= 32'h0;
      end else if (nrdy_q) begin
        if (init_q == INIT_CYC - 1) begin
          nrdy_q <= 1'b0;
        end else begin
          init_q <= init_q + 32'h1;
        end
      end
    end
  end
  assign done_ev = nrdy_q & ~soft_rst & (init_q == INIT_CYC - 1);

  // sticky flags, write one to clear, set wins
  assign flg_set = {fault_i & {4{~nrdy_q}}, done_ev};
  assign flg_clr = (wr_q && wadr_q == REG_FLAGS) ? wdat_q[4:0] : 5'h00;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_q <= 5'h00;
    end else if (clk_en_i) begin
      if (soft_rst) begin
        flags_q <= 5'h00;
      end else begin
        flags_q <= (flags_q & ~flg_clr) | flg_set;
      end
    end
  end

  // writable settings
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mask_q     <= MASK_RST;
      lane_off_q <= LANE_OFF_RST;
    end else if (clk_en_i) begin
      if (soft_rst) begin
        mask_q     <= MASK_RST;
        lane_off_q <= LANE_OFF_RST;
      end else if (wr_q) begin
        if (wadr_q == REG_MASK) begin
          mask_q <= wdat_q[4:0];
        end
        if (wadr_q == REG_LANE_OFF) begin
          lane_off_q <= wdat_q[3:0];
        end
      end
    end
  end

  // pins and module-side outputs
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      link.d_sda_o  <= 1'b0;
      link.d_int_o  <= 1'b0;
      link.d_int_oe <= 1'b0;
      link.d_prs_o  <= 1'b0;
      link.d_prs_oe <= 1'b0;
      lane_enable_o <= 4'h0;
      power_limit_o <= 1'b0;
      ready_o       <= 1'b0;
    end else if (clk_en_i) begin
      link.d_int_oe <= |(flags_q & ~mask_q);
      link.d_prs_oe <= inserted_i;
      lane_enable_o <= ~lane_off_q & {4{~nrdy_q}};
      power_limit_o <= s_lp;
      ready_o       <= ~nrdy_q;
    end
  end

  function automatic logic [7:0] rd_map(input logic [7:0] a);
    case (a)
      REG_STATUS:   rd_map = {5'h00, inserted_i, s_lp, nrdy_q};
      REG_FLAGS:    rd_map = {3'h0, flags_q};
      REG_MASK:     rd_map = {3'h0, mask_q};
      REG_LANE_OFF: rd_map = {4'h0, lane_off_q};
      default:      rd_map = 8'h00;
    endcase
  endfunction

  // serial slave
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q          <= SL_IDLE;
      sh_q          <= 8'h00;
      ptr_q         <= 8'h00;
      bit_q         <= 3'h0;
      phase_q       <= 2'h0;
      rw_q          <= 1'b0;
      nack_q        <= 1'b0;
      wr_q          <= 1'b0;
      wadr_q        <= 8'h00;
      wdat_q        <= 8'h00;
      link.d_sda_oe <= 1'b0;
    end else if (clk_en_i) begin
      wr_q <= 1'b0;
      if (s_sel_n || stop || soft_rst) begin
        st_q          <= SL_IDLE;
        link.d_sda_oe <= 1'b0;
      end else if (start) begin
        st_q          <= SL_RECV;
        bit_q         <= 3'h0;
        phase_q       <= 2'h0;
        link.d_sda_oe <= 1'b0;
      end else begin
        case (st_q)
          SL_RECV: if (scl_rise) begin
            sh_q  <= rx_byte;
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              st_q <= SL_ACK;
              if (phase_q == 2'h0) begin
                rw_q <= s_sda;
                if (rx_byte[7:1] != DEV_ADDR) begin
                  st_q <= SL_IDLE;
                end
              end else if (phase_q == 2'h1) begin
                ptr_q <= rx_byte;
              end else begin
                wr_q   <= 1'b1;
                wadr_q <= ptr_q;
                wdat_q <= rx_byte;
                ptr_q  <= ptr_q + 8'h01;
              end
              if (phase_q != 2'h2) begin
                phase_q <= phase_q + 2'h1;
              end
            end
          end
          SL_ACK: if (scl_fall) begin
            bit_q <= 3'h0;
            if (!link.d_sda_oe) begin
              link.d_sda_oe <= 1'b1;
            end else if (rw_q) begin
              st_q          <= SL_SEND;
              sh_q          <= rd_map(ptr_q);
              link.d_sda_oe <= (rd_map(ptr_q) < 8'h80);
              ptr_q         <= ptr_q + 8'h01;
            end else begin
              st_q          <= SL_RECV;
              link.d_sda_oe <= 1'b0;
            end
          end
          SL_SEND: if (scl_fall) begin
            bit_q <= bit_q + 3'h1;
            sh_q  <= {sh_q[6:0], 1'b0};
            if (bit_q == 3'h7) begin
              st_q          <= SL_RACK;
              link.d_sda_oe <= 1'b0;
            end else begin
              link.d_sda_oe <= ~sh_q[6];
            end
          end
          SL_RACK: begin
            if (scl_rise) begin
              nack_q <= s_sda;
            end
            if (scl_fall) begin
              bit_q <= 3'h0;
              if (nack_q) begin
                st_q <= SL_IDLE;
              end else begin
                st_q          <= SL_SEND;
                sh_q          <= rd_map(ptr_q);
                link.d_sda_oe <= (rd_map(ptr_q) < 8'h80);
                ptr_q         <= ptr_q + 8'h01;
              end
            end
          end
          default: st_q <= SL_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: verilog/omlsc_host.sv
`timescale 1ns/10ps
`default_nettype none
module omlsc_host
  import omlsc_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        clk_en_i,
  // link
  omlsc_link_if.host       link,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output var  logic [31:0] rdata_o,
  output var  logic        irq_o
);
  logic [2:0]    pin_s;
  logic          s_sda;
  logic          s_att;
  logic          s_prs;
  logic          att_p_q;
  logic          prs_p_q;
  logic [1:0]    ctrl_q;
  logic          wait_q;
  logic [2:0]    irq_q;
  logic [2:0]    mask_q;
  logic [2:0]    irq_set;
  omlsc_mst_type st_q;
  logic [7:0]    qc_q;
  logic [1:0]    ph_q;
  logic [3:0]    bit_q;
  logic [1:0]    idx_q;
  logic          rs_q;
  logic          rdop_q;
  logic          nack_q;
  logic [7:0]    ptr_q;
  logic [7:0]    wdat_q;
  logic [7:0]    rx_q;
  logic          tick;
  logic          rdbyte;
  logic [7:0]    tx;
  logic          scl_oe_d;
  logic          sda_oe_d;
  logic          go;

  omlsc_sync #(
    .W   (3),
    .RST (3'h7)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .clk_en_i  (clk_en_i),
    .d_i       ({link.sda, link.attention_n, link.module_present_n}),
    .q_o       (pin_s)
  );
  assign {s_sda, s_att, s_prs} = pin_s;

  assign tick   = (st_q != MS_IDLE) && (qc_q == 8'(SCL_QUARTER - 1));
  assign rdbyte = rdop_q && (idx_q == 2'h3);
  assign tx     = (idx_q == 2'h0) ? {DEV_ADDR, 1'b0} :
                  (idx_q == 2'h1) ? ptr_q :
                  (rdop_q ? {DEV_ADDR, 1'b1} : wdat_q);
  assign go     = wr_i && addr_i == HREG_CMD && st_q == MS_IDLE && !wait_q;
  assign irq_set = {s_prs ^ prs_p_q, att_p_q & ~s_att,
                    tick && st_q == MS_STOP && ph_q == 2'h3};

  // line drive per phase
  always_comb begin
    scl_oe_d = 1'b0;
    sda_oe_d = 1'b0;
    case (st_q)
      MS_START: begin
        scl_oe_d = (ph_q == 2'h0 && rs_q) || ph_q == 2'h3;
        sda_oe_d = ph_q >= 2'h2;
      end
      MS_BIT: begin
        scl_oe_d = ph_q == 2'h0 || ph_q == 2'h3;
        sda_oe_d = bit_q < 4'h8 && !rdbyte && !tx[3'h7 - bit_q[2:0]];
      end
      MS_STOP: begin
        scl_oe_d = ph_q == 2'h0;
        sda_oe_d = ph_q <= 2'h1;
      end
      default: ;
    endcase
  end

  // serial master sequencer
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q   <= MS_IDLE;
      qc_q   <= 8'h00;
      ph_q   <= 2'h0;
      bit_q  <= 4'h0;
      idx_q  <= 2'h0;
      rs_q   <= 1'b0;
      rdop_q <= 1'b0;
      nack_q <= 1'b0;
      ptr_q  <= 8'h00;
      wdat_q <= 8'h00;
      rx_q   <= 8'h00;
    end else if (clk_en_i) begin
      if (go) begin
        st_q   <= MS_START;
        {qc_q, ph_q, bit_q, idx_q, rs_q, nack_q} <= 18'h0;
        ptr_q  <= wdata_i[7:0];
        wdat_q <= wdata_i[15:8];
        rdop_q <= wdata_i[16];
      end else if (st_q != MS_IDLE) begin
        qc_q <= tick ? 8'h00 : qc_q + 8'h01;
        if (tick) begin
          ph_q <= ph_q + 2'h1;
          case (st_q)
            MS_START: if (ph_q == 2'h3) begin
              st_q  <= MS_BIT;
              bit_q <= 4'h0;
            end
            MS_BIT: begin
              if (ph_q == 2'h2 && rdbyte && bit_q < 4'h8) begin
                rx_q <= {rx_q[6:0], s_sda};
              end
              if (ph_q == 2'h2 && !rdbyte && bit_q == 4'h8) begin
                nack_q <= nack_q | s_sda;
              end
              if (ph_q == 2'h3) begin
                bit_q <= bit_q + 4'h1;
                if (bit_q == 4'h8) begin
                  bit_q <= 4'h0;
                  idx_q <= idx_q + 2'h1;
                  if (nack_q || (!rdop_q && idx_q == 2'h2) || idx_q == 2'h3) begin
                    st_q <= MS_STOP;
                  end else if (rdop_q && idx_q == 2'h1) begin
                    st_q <= MS_START;
                    rs_q <= 1'b1;
                  end
                end
              end
            end
            MS_STOP: if (ph_q == 2'h3) begin
              st_q <= MS_IDLE;
            end
            default: st_q <= MS_IDLE;
          endcase
        end
      end
    end
  end

  // pins
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      link.h_scl_o           <= 1'b0;
      link.h_sda_o           <= 1'b0;
      link.h_scl_oe          <= 1'b0;
      link.h_sda_oe          <= 1'b0;
      link.module_select_n   <= 1'b1;
      link.module_reset_n    <= 1'b1;
      link.low_power_request <= 1'b0;
    end else if (clk_en_i) begin
      link.h_scl_oe          <= scl_oe_d;
      link.h_sda_oe          <= sda_oe_d;
      link.module_select_n   <= st_q == MS_IDLE;
      link.module_reset_n    <= ~ctrl_q[0];
      link.low_power_request <= ctrl_q[1];
    end
  end

  // control, reset wait, interrupts
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q  <= CTRL_RST;
      wait_q  <= 1'b1;
      irq_q   <= 3'h0;
      mask_q  <= HMASK_RST;
      att_p_q <= 1'b1;
      prs_p_q <= 1'b1;
      irq_o   <= 1'b0;
    end else if (clk_en_i) begin
      att_p_q <= s_att;
      prs_p_q <= s_prs;
      if (wr_i && addr_i == HREG_CTRL) begin
        ctrl_q <= wdata_i[1:0];
      end
      if (irq_set[1]) begin
        wait_q <= 1'b0;
      end else if (wr_i && addr_i == HREG_CTRL && wdata_i[0]) begin
        wait_q <= 1'b1;
      end
      if (wr_i && addr_i == HREG_MASK) begin
        mask_q <= wdata_i[2:0];
      end
      irq_q <= (irq_q & ~((wr_i && addr_i == HREG_IRQ) ? wdata_i[2:0] : 3'h0))
               | irq_set;
      irq_o <= |(irq_q & mask_q);
    end
  end

  // register reads
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0;
    end else if (clk_en_i) begin
      rdata_o <= 32'h0;
      if (rd_i) begin
        case (addr_i)
          HREG_CTRL: rdata_o <= {30'h0, ctrl_q};
          HREG_CMD:  rdata_o <= {15'h0, rdop_q, wdat_q, ptr_q};
          HREG_STAT: rdata_o <= {16'h0, rx_q, 3'h0, wait_q, ~s_att, ~s_prs,
                                 nack_q, st_q != MS_IDLE};
          HREG_IRQ:  rdata_o <= {29'h0, irq_q};
          HREG_MASK: rdata_o <= {29'h0, mask_q};
          default:   rdata_o <= 32'h0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: verilog/omlsc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module omlsc_sync #(
  parameter int unsigned  W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  input  wire logic         clk_en_i,
  // levels
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  // output follows once stages two and three agree
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
      q_o  <= RST;
    end else if (clk_en_i) begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_o  <= (s2_q & ~(s2_q ^ s3_q)) | (q_o & (s2_q ^ s3_q));
    end
  end
endmodule
`default_nettype wire
